// *** logic/uss_pkg.sv ***
`default_nettype none
package uss_pkg;
    // ----------------------------------------
    // Bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // ----------------------------------------
    // Register indices, byte address is index * 4
    // ----------------------------------------
    localparam logic [7:0] IDX_FLAGS   = 8'h0c;
    localparam logic [7:0] IDX_RXSC    = 8'h18;
    localparam logic [7:0] IDX_TXBUF   = 8'h19;
    localparam logic [7:0] IDX_RXBUF   = 8'h1a;
    localparam logic [7:0] IDX_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_TXSC    = 8'h98;
    localparam logic [7:0] IDX_BAUD    = 8'h99;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FLG_RX_FULL  = 5;
    localparam int FLG_TX_EMPTY = 4;
    localparam int EN_RX_IRQ    = 5;
    localparam int EN_TX_IRQ    = 4;
    localparam int RX_SERIAL_PORT_ENABLE      = 7;
    localparam int RX_NINE      = 6;
    localparam int RX_SINGLE    = 5;
    localparam int RX_CONT      = 4;
    localparam int RX_FERR      = 2;
    localparam int RX_OERR      = 1;
    localparam int RX_D9        = 0;
    localparam int TX_CLOCK_SOURCE_SELECT      = 7;
    localparam int TX_NINE      = 6;
    localparam int TX_EN        = 5;
    localparam int TX_SYNC      = 4;
    localparam int TX_TX_SHIFT_EMPTY      = 1;
    localparam int TX_D9        = 0;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [7:0] RST_FLAGS   = 8'h00;
    localparam logic [7:0] RST_RXSC    = 8'h00;
    localparam logic [7:0] RST_TXBUF   = 8'h00;
    localparam logic [7:0] RST_RXBUF   = 8'h00;
    localparam logic [7:0] RST_ENABLES = 8'h00;
    localparam logic [7:0] RST_TXSC    = 8'h02;
    localparam logic [7:0] RST_BAUD    = 8'h00;
    localparam logic [7:0] TXSC_WMASK  = 8'hf5;
    localparam logic [3:0] BITS_8      = 4'h8;
    localparam logic [3:0] BITS_9      = 4'h9;

    typedef enum {ST_IDLE, ST_TX, ST_RX} uss_state_t;

    typedef struct packed {
        logic clock_out;
        logic clock_oe;
        logic data_out;
        logic data_oe;
    } uss_pins_t;
endpackage
`default_nettype wire

// *** logic/uss_sync_port.sv ***
`timescale 1ns/1ps
`default_nettype none
module uss_sync_port (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic                       clk_en,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [uss_pkg::ADDR_W-1:0] paddr,
    input  wire logic [uss_pkg::DATA_W-1:0] pwdata,
    output logic      [uss_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       cpu_sleep,
    input  wire logic                       sync_clock_pin_in,
    input  wire logic                       sync_data_pin_in,
    output uss_pkg::uss_pins_t              link_out,
    output logic                            irq,
    output logic                            wake
);
    import uss_pkg::*;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[ADDR_W-1:2];
        return (a[1:0] == 2'b00) && (i == IDX_FLAGS || i == IDX_RXSC
            || i == IDX_TXBUF || i == IDX_RXBUF || i == IDX_ENABLES
            || i == IDX_TXSC || i == IDX_BAUD);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]  rxsc;
    logic [7:0]  txsc;
    logic [7:0]  enables;
    logic [7:0]  baud;
    logic [7:0]  tx_buf;
    logic        tx_buf_full;
    logic [7:0]  rx_buf;
    logic        rx_full;
    uss_state_t  state;
    logic [8:0]  shreg;
    logic [3:0]  bitcnt;
    logic [7:0]  baud_cnt;
    logic        sclk;
    logic        ck_s1;
    logic        ck_s2;
    logic        ck_s3;
    logic        dt_s1;
    logic        dt_s2;
    logic        prd_ok;
    logic [7:0]  next_rxsc;
    logic [7:0]  next_txsc;
    logic [7:0]  next_enables;
    logic [7:0]  next_baud;
    logic [7:0]  next_tx_buf;
    logic        next_tx_buf_full;
    logic [7:0]  next_rx_buf;
    logic        next_rx_full;
    uss_state_t  next_state;
    logic [8:0]  next_shreg;
    logic [3:0]  next_bitcnt;
    logic [7:0]  next_baud_cnt;
    logic        next_sclk;
    logic        next_prd_ok;
    logic [31:0] next_prdata;

    logic [7:0]  idx;
    logic        mapped;
    logic        acc_done;
    logic        wr;
    logic        rd_rxbuf;
    logic [7:0]  rd_mux;
    logic        tx_flag;
    logic        tx_shift_empty;
    logic        active;
    logic        master;
    logic        rx_en;
    logic        tick;
    logic        shift_ev;
    logic [3:0]  tx_bits;
    logic [3:0]  rx_bits;
    logic [8:0]  rx_sh;

    assign idx      = paddr[ADDR_W-1:2];
    assign mapped   = is_mapped(paddr);
    assign pready   = clk_en & prd_ok;
    assign pslverr  = pready & penable & ~mapped;
    assign acc_done = psel & penable & pready;
    assign wr       = acc_done & pwrite & mapped;
    assign rd_rxbuf = acc_done & ~pwrite & mapped & (idx == IDX_RXBUF);

    // ----------------------------------------
    // Status and mode decode
    // ----------------------------------------
    // shifter empty status
    assign tx_shift_empty    = (state != ST_TX);
    assign tx_flag = txsc[TX_EN] & ~tx_buf_full;
    assign active  = rxsc[RX_SERIAL_PORT_ENABLE] & txsc[TX_SYNC];
    assign master  = txsc[TX_CLOCK_SOURCE_SELECT];
    assign rx_en   = rxsc[RX_CONT] | (master & rxsc[RX_SINGLE]);
    assign tx_bits = txsc[TX_NINE] ? BITS_9 : BITS_8;
    assign rx_bits = rxsc[RX_NINE] ? BITS_9 : BITS_8;
    assign tick    = master & (state != ST_IDLE) & ~cpu_sleep
                     & (baud_cnt == baud);
    // slave clock needs no core clock pacing
    assign shift_ev = master ? (tick & sclk) : (~ck_s2 & ck_s3);
    assign rx_sh    = {dt_s2, shreg[8:1]};

    assign irq  = (tx_flag & enables[EN_TX_IRQ])
                | (rx_full & enables[EN_RX_IRQ]);
    assign wake = cpu_sleep & irq;

    // pins handed over only when enabled
    // data pin driven only while sending
    always_comb begin
        link_out.clock_out = sclk;
        link_out.clock_oe  = active & master & (state != ST_IDLE);
        link_out.data_out  = shreg[0];
        link_out.data_oe   = active & (state == ST_TX);
    end

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    // no index reaches the shifter
    always_comb begin
        rd_mux = 8'h00;
        case (idx)
            IDX_FLAGS: begin
                rd_mux[FLG_RX_FULL]  = rx_full;
                rd_mux[FLG_TX_EMPTY] = tx_flag;
            end
            IDX_RXSC:    rd_mux = rxsc;
            IDX_TXBUF:   rd_mux = tx_buf;
            IDX_RXBUF:   rd_mux = rx_buf;
            IDX_ENABLES: rd_mux = enables;
            IDX_TXSC:    rd_mux = txsc | {6'h00, tx_shift_empty, 1'b0};
            IDX_BAUD:    rd_mux = baud;
            default:     rd_mux = 8'h00;
        endcase
        if (!mapped) begin
            rd_mux = 8'h00;
        end
    end

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        next_rxsc        = rxsc;
        next_txsc        = txsc;
        next_enables     = enables;
        next_baud        = baud;
        next_tx_buf      = tx_buf;
        next_tx_buf_full = tx_buf_full;
        next_rx_buf      = rx_buf;
        next_rx_full     = rx_full;
        next_state       = state;
        next_shreg       = shreg;
        next_bitcnt      = bitcnt;
        next_baud_cnt    = baud_cnt;
        next_sclk        = sclk;
        next_prd_ok      = prd_ok;
        next_prdata      = prdata;

        // Bus setup captures read data
        if (psel && !penable) begin
            next_prd_ok = 1'b1;
            next_prdata = {24'h000000, rd_mux};
        end else if (acc_done) begin
            next_prd_ok = 1'b0;
        end

        // Software writes
        if (wr) begin
            case (idx)
                IDX_RXSC: begin
                    next_rxsc[7:4] = pwdata[7:4];
                    if (!pwdata[RX_CONT]) begin
                        next_rxsc[RX_FERR] = 1'b0;
                        next_rxsc[RX_OERR] = 1'b0;
                    end
                end
                IDX_TXBUF: begin
                    next_tx_buf      = pwdata[7:0];
                    next_tx_buf_full = 1'b1;
                end
                IDX_ENABLES: next_enables = pwdata[7:0];
                IDX_TXSC:    next_txsc = pwdata[7:0] & TXSC_WMASK;
                IDX_BAUD:    next_baud = pwdata[7:0];
                default: begin
                end
            endcase
        end
        if (rd_rxbuf) begin
            next_rx_full = 1'b0;
        end

        // Master clock divider
        if (tick) begin
            next_baud_cnt = 8'h00;
            next_sclk     = ~sclk;
        end else if (master && state != ST_IDLE && !cpu_sleep) begin
            next_baud_cnt = baud_cnt + 8'h01;
        end

        case (state)
            ST_IDLE: begin
                next_sclk     = 1'b0;
                next_baud_cnt = 8'h00;
                next_bitcnt   = 4'h0;
                if (active && txsc[TX_EN] && tx_buf_full) begin
                    next_state  = ST_TX;
                    next_shreg  = {txsc[TX_D9], tx_buf};
                    next_tx_buf_full = wr && idx == IDX_TXBUF;
                end else if (active && rx_en) begin
                    next_state = ST_RX;
                end
            end
            ST_TX: begin
                if (!active) begin
                    next_state = ST_IDLE;
                    next_sclk  = 1'b0;
                end else if (shift_ev) begin
                    if (bitcnt == tx_bits - 4'h1) begin
                        next_bitcnt = 4'h0;
                        if (txsc[TX_EN] && tx_buf_full) begin
                            next_shreg = {txsc[TX_D9], tx_buf};
                            next_tx_buf_full = wr && idx == IDX_TXBUF;
                        end else begin
                            next_state = ST_IDLE;
                        end
                    end else begin
                        next_shreg  = {1'b0, shreg[8:1]};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                end
            end
            ST_RX: begin
                if (!active || !rx_en) begin
                    next_state = ST_IDLE;
                    next_sclk  = 1'b0;
                end else if (shift_ev) begin
                    next_shreg = rx_sh;
                    if (bitcnt == rx_bits - 4'h1) begin
                        next_bitcnt = 4'h0;
                        if (rx_full && !rd_rxbuf) begin
                            next_rxsc[RX_OERR] = 1'b1;
                        end else begin
                            next_rx_full = 1'b1;
                            next_rx_buf  = rxsc[RX_NINE] ? rx_sh[7:0]
                                                         : rx_sh[8:1];
                            next_rxsc[RX_D9] = rxsc[RX_NINE] & rx_sh[8];
                        end
                        if (!rxsc[RX_CONT]) begin
                            next_rxsc[RX_SINGLE] = 1'b0;
                            next_state = ST_IDLE;
                        end
                    end else begin
                        next_bitcnt = bitcnt + 4'h1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxsc        <= RST_RXSC;
            txsc        <= RST_TXSC & TXSC_WMASK;
            enables     <= RST_ENABLES;
            baud        <= RST_BAUD;
            tx_buf      <= RST_TXBUF;
            tx_buf_full <= 1'b0;
            rx_buf      <= RST_RXBUF;
            rx_full     <= RST_FLAGS[FLG_RX_FULL];
            state       <= ST_IDLE;
            shreg       <= 9'h000;
            bitcnt      <= 4'h0;
            baud_cnt    <= 8'h00;
            sclk        <= 1'b0;
            ck_s1       <= 1'b0;
            ck_s2       <= 1'b0;
            ck_s3       <= 1'b0;
            dt_s1       <= 1'b0;
            dt_s2       <= 1'b0;
            prd_ok      <= 1'b0;
            prdata      <= 32'h00000000;
        end else if (clk_en) begin
            rxsc        <= next_rxsc;
            txsc        <= next_txsc;
            enables     <= next_enables;
            baud        <= next_baud;
            tx_buf      <= next_tx_buf;
            tx_buf_full <= next_tx_buf_full;
            rx_buf      <= next_rx_buf;
            rx_full     <= next_rx_full;
            state       <= next_state;
            shreg       <= next_shreg;
            bitcnt      <= next_bitcnt;
            baud_cnt    <= next_baud_cnt;
            sclk        <= next_sclk;
            // slave clock enters from the pin
            ck_s1       <= sync_clock_pin_in;
            ck_s2       <= ck_s1;
            ck_s3       <= ck_s2;
            dt_s1       <= sync_data_pin_in;
            dt_s2       <= dt_s1;
            prd_ok      <= next_prd_ok;
            prdata      <= next_prdata;
        end
    end
endmodule
`default_nettype wire

// *** verification/uss_sync_port_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module uss_props (
    input wire logic                       ref_clk,
    input wire logic                       rst_n,
    input wire logic                       clk_en,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic [uss_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       cpu_sleep,
    input wire uss_pkg::uss_pins_t         link_out,
    input wire logic                       irq,
    input wire logic                       wake
);
    import uss_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Bus properties
    // ----------------------------------------
    property p_ready_access;
        psel && penable && clk_en |-> pready;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("no ready");
    property p_ready_setup;
        psel && !penable |-> !pready;
    endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("early ready");
    property p_slverr;
        pslverr |-> pready && psel && penable;
    endproperty
    a_slverr: assert property (p_slverr) else $error("stray slverr");
    property p_prdata_hold;
        !(psel && !penable && clk_en) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
    property p_upper_zero;
        prdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
    // ----------------------------------------
    // Link and wake properties
    // ----------------------------------------
    property p_wake;
        wake == (irq && cpu_sleep);
    endproperty
    a_wake: assert property (p_wake) else $error("wake mismatch");
    property p_clk_idle;
        !link_out.clock_oe |-> !link_out.clock_out;
    endproperty
    a_clk_idle: assert property (p_clk_idle) else $error("clock not idle low");
    property p_first_low;
        $rose(link_out.clock_oe) |-> !link_out.clock_out;
    endproperty
    a_first_low: assert property (p_first_low) else $error("first half high");
    property p_data_hold;
        link_out.data_oe && link_out.clock_out && $past(link_out.clock_out)
            |-> $stable(link_out.data_out);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved");
    c_tx: cover property (link_out.data_oe && $rose(link_out.clock_out));
    c_rx: cover property (link_out.clock_oe && !link_out.data_oe);
    c_wake: cover property ($rose(wake));
endmodule
bind uss_sync_port uss_props chk_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_sleep(cpu_sleep),
    .link_out(link_out), .irq(irq), .wake(wake)
);
`default_nettype wire

// *** verification/uss_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module uss_partner (
    input wire logic sclk,
    input wire logic sdat,
    output logic     ck_out,
    output logic     dt_out
);
    logic [8:0]  resp;
    logic [3:0]  nbits;
    logic [3:0]  idx;
    logic [31:0] cap;
    logic        armed;
    initial begin
        ck_out = 1'b0;
        dt_out = 1'b0;
        armed = 1'b0;
        cap = 32'h0;
    end
    // ----------------------------------------
    // Capture and response
    // ----------------------------------------
    always @(posedge sclk) begin
        cap <= {sdat, cap[31:1]};
    end
    always @(negedge sclk) begin
        if (armed) begin
            idx = (idx == nbits - 4'h1) ? 4'h0 : idx + 4'h1;
            dt_out <= resp[idx];
        end
    end
    task automatic arm(input logic [8:0] w, input logic [3:0] n);
        resp = w;
        nbits = n;
        idx = 4'h0;
        dt_out = w[0];
        armed = 1'b1;
    endtask
    task automatic disarm();
        armed = 1'b0;
        dt_out = ~dt_out;
    endtask
    task automatic clock_frame(input int n);
        repeat (n) begin
            #62.5 ck_out = 1'b1;
            #62.5 ck_out = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// *** verification/uss_sync_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module uss_sync_port_tb;
    import uss_pkg::*;
    logic                ref_clk, rst_n, clk_en, psel, penable, pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata, prdata, rdata;
    logic                pready, pslverr, cpu_sleep, irq, wake, rerr;
    logic                sclk, sdat, ck_out, dt_out;
    uss_pkg::uss_pins_t  link_out;
    int                  fail_count, n_checks;
    logic [7:0]          rix [7] = '{IDX_FLAGS, IDX_RXSC, IDX_TXBUF, IDX_RXBUF,
                                     IDX_ENABLES, IDX_TXSC, IDX_BAUD};
    logic [7:0]          rex [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    assign sclk = link_out.clock_oe ? link_out.clock_out : ck_out;
    assign sdat = link_out.data_oe ? link_out.data_out : dt_out;
    uss_sync_port dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_sleep(cpu_sleep),
        .sync_clock_pin_in(sclk), .sync_data_pin_in(sdat), .link_out(link_out),
        .irq(irq), .wake(wake)
    );
    uss_partner part_u (.sclk(sclk), .sdat(sdat), .ck_out(ck_out), .dt_out(dt_out));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic poll(input logic [7:0] ix, input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, ix, 8'h00);
            n++;
        end while (rdata[b] !== v && n < 2000);
        chk("poll", {31'h0, v}, {31'h0, rdata[b]});
    endtask
    task automatic rdchk(input string nm, input logic [7:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        chk(nm, {24'h0, e}, rdata);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 7; i++) begin
            rdchk("reset", rix[i], rex[i]);
        end
        apb(1'b0, 8'h3f, 8'h00);
        chk("unmapped", 32'h1, {31'h0, rerr});
        apb(1'b1, IDX_TXSC, 8'h00);
        rdchk("ro_shift_empty", IDX_TXSC, 8'h02);
    endtask
    task automatic t_master_tx();
        apb(1'b1, IDX_BAUD, 8'h01);
        apb(1'b1, IDX_RXSC, 8'h80);
        apb(1'b1, IDX_TXSC, 8'hf1);
        rdchk("flag_idle", IDX_FLAGS, 8'h10);
        chk("no_start", 32'h0, {31'h0, link_out.clock_oe});
        apb(1'b1, IDX_ENABLES, 8'h10);
        @(negedge ref_clk);
        chk("irq_on", 32'h1, {31'h0, irq});
        apb(1'b1, IDX_ENABLES, 8'h00);
        @(negedge ref_clk);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, IDX_FLAGS, 8'h00);
        rdchk("flag_kept", IDX_FLAGS, 8'h10);
        apb(1'b1, IDX_TXBUF, 8'ha5);
        apb(1'b1, IDX_TXBUF, 8'h3c);
        rdchk("flag_queued", IDX_FLAGS, 8'h00);
        rdchk("shift_busy", IDX_TXSC, 8'hf1);
        poll(IDX_TXSC, TX_TX_SHIFT_EMPTY, 1'b1);
        chk("tx_words", {14'h0, 9'h13c, 9'h1a5}, {14'h0, part_u.cap[31:14]});
        rdchk("flag_after", IDX_FLAGS, 8'h10);
        apb(1'b1, IDX_TXSC, 8'h90);
    endtask
    task automatic t_rx_single();
        part_u.arm(9'h15a, 4'h9);
        apb(1'b1, IDX_RXSC, 8'he0);
        poll(IDX_FLAGS, FLG_RX_FULL, 1'b1);
        rdchk("rx_status", IDX_RXSC, 8'hc1);
        rdchk("rx_data", IDX_RXBUF, 8'h5a);
        repeat (60) @(posedge ref_clk);
        chk("rx_stopped", 32'h0, {31'h0, link_out.clock_oe});
        rdchk("full_cleared", IDX_FLAGS, 8'h00);
        part_u.disarm();
    endtask
    task automatic t_rx_cont();
        part_u.arm(9'h0c3, 4'h8);
        apb(1'b1, IDX_ENABLES, 8'h20);
        apb(1'b1, IDX_RXSC, 8'hb0);
        poll(IDX_FLAGS, FLG_RX_FULL, 1'b1);
        @(negedge ref_clk);
        chk("rx_irq", 32'h1, {31'h0, irq});
        poll(IDX_RXSC, RX_OERR, 1'b1);
        rdchk("cont_data", IDX_RXBUF, 8'hc3);
        apb(1'b1, IDX_RXSC, 8'h80);
        apb(1'b1, IDX_RXSC, 8'h80);
        apb(1'b0, IDX_RXSC, 8'h00);
        chk("err_cleared", {25'h0, 7'h40}, {25'h0, rdata[7:1]});
        apb(1'b0, IDX_RXBUF, 8'h00);
        apb(1'b1, IDX_ENABLES, 8'h00);
        part_u.disarm();
    endtask
    task automatic t_slave_sleep();
        apb(1'b1, IDX_TXSC, 8'h30);
        apb(1'b1, IDX_ENABLES, 8'h10);
        apb(1'b1, IDX_TXBUF, 8'h96);
        apb(1'b1, IDX_TXBUF, 8'h4b);
        cpu_sleep <= 1'b1;
        rdchk("slave_queued", IDX_FLAGS, 8'h00);
        chk("no_wake", 32'h0, {31'h0, wake});
        #3 part_u.clock_frame(16);
        repeat (6) @(posedge ref_clk);
        chk("slave_words", {16'h0, 8'h4b, 8'h96}, {16'h0, part_u.cap[31:16]});
        rdchk("slave_flag", IDX_FLAGS, 8'h10);
        @(negedge ref_clk);
        chk("wake", 32'h1, {31'h0, wake});
        cpu_sleep <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        #500000;
        fail_count++;
        stop_test();
    end
    initial begin
        {rst_n, psel, penable, pwrite, cpu_sleep} = 5'h00;
        clk_en = 1'b1;
        paddr = '0;
        pwdata = '0;
        fail_count = 0;
        n_checks = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_master_tx();
        t_rx_single();
        t_rx_cont();
        t_slave_sleep();
        stop_test();
    end
endmodule
`default_nettype wire
